/* shared/asp_pkg.sv */
// Shared constants and types for the asynchronous serial port
package asp_pkg;

  // ********************
  // Register byte addresses
  // ********************
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_STA  = 8'h04;
  localparam logic [7:0] ADDR_TX   = 8'h08;
  localparam logic [7:0] ADDR_RX   = 8'h0c;
  localparam logic [7:0] ADDR_BRG  = 8'h10;

  // ********************
  // Reset values and masks
  // ********************
  localparam logic [15:0] MODE_RST   = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'hbbff;
  localparam logic [15:0] BRG_RST    = 16'h0000;

  // ********************
  // Status register bit positions
  // ********************
  localparam int STA_TXSEL1 = 15;
  localparam int STA_TXINV  = 14;
  localparam int STA_TXSEL0 = 13;
  localparam int STA_BRK    = 11;
  localparam int STA_TXEN   = 10;
  localparam int STA_RXSEL  = 6;
  localparam int STA_ADDEN  = 5;
  localparam int STA_OVERRUN_FLAG   = 1;

  // ********************
  // Bit timing
  // ********************
  localparam logic [3:0] OVS_STD_LAST = 4'hf;
  localparam logic [3:0] OVS_HS_LAST  = 4'h3;
  localparam logic [3:0] HALF_STD     = 4'h7;
  localparam logic [3:0] HALF_HS      = 4'h1;
  localparam logic [3:0] IR_PULSE_LO  = 4'h7;
  localparam logic [3:0] IR_PULSE_HI  = 4'h9;
  localparam logic [14:0] BRK_FRAME   = 15'h6000;
  localparam logic [3:0] BRK_LEN      = 4'he;
  localparam logic [2:0] AB_LAST_EDGE = 3'h4;
  localparam int AB_SHIFT_STD = 7;
  localparam int AB_SHIFT_HS  = 5;

  // ********************
  // Types
  // ********************
  typedef enum logic [1:0] {PW_8N, PW_8E, PW_8O, PW_9N} asp_pw_type;

  typedef struct packed {
    logic       serial_unit_on;
    logic       rsv14;
    logic       halt_when_idle;
    logic       infrared_codec_enable;
    logic       rts_behaviour_select;
    logic       rsv10;
    logic [1:0] pin_usage_select;
    logic       wake_enable;
    logic       internal_echo_select;
    logic       auto_rate_measure;
    logic       rx_polarity_invert;
    logic       high_speed_baud_select;
    asp_pw_type parity_width_select;
    logic       stop_count_select;
  } asp_mode_type;

  typedef struct packed {
    logic       parity_error_flag;
    logic       framing_error_flag;
    logic [8:0] data;
  } asp_rx_entry_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       byte_size;
  } asp_ahb_req_type;

endpackage

/* src/asp_fifo.sv */
// Small synchronous FIFO for transmit and receive characters
`timescale 1ns/1ps
`default_nettype none
module asp_fifo
  import asp_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4,
  localparam int CW   = $clog2(DEPTH + 1),
  localparam int AW   = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  // State
  output logic [WIDTH-1:0]      rdata,
  output logic [CW-1:0]         count,
  output logic                  full,
  output logic                  empty
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [CW-1:0]    cnt_q;
  logic             do_push;
  logic             do_pop;

  // Depth is a power of two so pointers wrap naturally
  assign do_push = push & ~full;
  assign do_pop  = pop & ~empty;
  assign full    = cnt_q == CW'(DEPTH);
  assign empty   = cnt_q == '0;
  assign count   = cnt_q;
  assign rdata   = mem[rp_q];

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      mem[wp_q] <= wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= wp_q + AW'(1);
      end
      if (do_pop) begin
        rp_q <= rp_q + AW'(1);
      end
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

endmodule
`default_nettype wire

/* src/asp_baud_gen.sv */
// Baud timer with clear, counting only while run is high and producing the oversampling tick
`timescale 1ns/1ps
`default_nettype none
module asp_baud_gen
  import asp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Control
  input  wire logic        run,
  input  wire logic        clear,
  input  wire logic [15:0] divisor,
  // Timing outputs
  output logic             tick,
  output logic             bclk
);

  logic [15:0] cnt_q;

  // One tick every divisor plus one clocks
  assign tick = run & (cnt_q == divisor);
  assign bclk = cnt_q <= (divisor >> 1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
    end else if (clear || tick) begin
      cnt_q <= 16'h0000;
    end else if (run) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule
`default_nettype wire

/* src/asp_top.sv */
// Asynchronous serial port with infrared codec behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module asp_top
  import asp_pkg::*;
#(
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Power state
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  // Serial pins
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             serial_out_oe,
  input  wire logic        clear_to_send_n,
  output logic             request_to_send_n,
  output logic             request_to_send_oe,
  // Event requests
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq,
  output logic             wake_irq
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} asp_rx_state_type;

  function automatic logic [14:0] tx_frame(input logic [8:0] d, input asp_pw_type pw);
    logic p;
    p = ^d[7:0];
    unique case (pw)
      PW_9N: tx_frame = {5'h1f, d, 1'b0};
      PW_8E: tx_frame = {5'h1f, p, d[7:0], 1'b0};
      PW_8O: tx_frame = {5'h1f, ~p, d[7:0], 1'b0};
      PW_8N: tx_frame = {6'h3f, d[7:0], 1'b0};
    endcase
  endfunction

  // ********************
  // Registers and bus state
  // ********************
  asp_mode_type     m_q;
  logic [15:0]      baud_divisor_q;
  logic [1:0]       txisel_q;
  logic [1:0]       rxisel_q;
  logic             txinv_q;
  logic             brk_q;
  logic             txen_q;
  logic             adden_q;
  logic             overrun_flag_q;
  asp_ahb_req_type  req_q;
  logic             dphase_q;
  logic [31:0]      hrdata_q;

  logic             take;
  logic             wr_mode;
  logic             wr_sta;
  logic             wr_tx;
  logic             wr_brg;
  logic             rd_rx;
  logic             txen_rise;
  logic             run;
  logic             tick;
  logic             bclk;
  logic             infrared_codec_enable_act;
  logic [3:0]       ovs_last;
  logic [3:0]       ovs_half;

  // ********************
  // AHB-Lite slave
  // ********************
  assign take      = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wr_mode   = dphase_q & req_q.write & (req_q.addr == ADDR_MODE);
  assign wr_sta    = dphase_q & req_q.write & (req_q.addr == ADDR_STA);
  assign wr_tx     = dphase_q & req_q.write & (req_q.addr == ADDR_TX);
  assign wr_brg    = dphase_q & req_q.write & (req_q.addr == ADDR_BRG);
  assign rd_rx     = take & ~hwrite & (haddr[7:0] == ADDR_RX);
  assign txen_rise = wr_sta & hwdata[STA_TXEN] & ~txen_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q    <= '0;
      dphase_q <= 1'b0;
    end else begin
      dphase_q <= take;
      if (take) begin
        req_q <= '{addr: haddr[7:0], write: hwrite, byte_size: hsize == 3'h0};
      end
    end
  end

  // ********************
  // Configuration registers
  // ********************
  logic             ab_done;
  logic [15:0]      ab_div;
  logic             wake_hit;
  logic             ovr;
  logic             tx_brk_done;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      m_q <= asp_mode_type'(MODE_RST);
    end else begin
      if (wr_mode) begin
        m_q <= asp_mode_type'(hwdata[15:0] & MODE_WMASK);
      end
      if (ab_done) begin
        m_q.auto_rate_measure <= 1'b0;
      end
      if (wake_hit) begin
        m_q.wake_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_divisor_q <= BRG_RST;
    end else if (ab_done) begin
      baud_divisor_q <= ab_div;
    end else if (wr_brg) begin
      baud_divisor_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txisel_q <= 2'h0;
      rxisel_q <= 2'h0;
      txinv_q  <= 1'b0;
      txen_q   <= 1'b0;
      adden_q  <= 1'b0;
      brk_q    <= 1'b0;
    end else begin
      if (wr_sta) begin
        txisel_q <= {hwdata[STA_TXSEL1], hwdata[STA_TXSEL0]};
        rxisel_q <= hwdata[STA_RXSEL+:2];
        txinv_q  <= hwdata[STA_TXINV];
        txen_q   <= hwdata[STA_TXEN];
        adden_q  <= hwdata[STA_ADDEN];
        brk_q    <= hwdata[STA_BRK];
      end
      if (tx_brk_done) begin
        brk_q <= 1'b0;
      end
    end
  end

  // ********************
  // Baud timing
  // ********************
  assign run      = m_q.serial_unit_on & ~(idle_mode & m_q.halt_when_idle);
  assign ovs_last = m_q.high_speed_baud_select ? OVS_HS_LAST : OVS_STD_LAST;
  assign ovs_half = m_q.high_speed_baud_select ? HALF_HS : HALF_STD;
  assign infrared_codec_enable_act = m_q.infrared_codec_enable & ~m_q.high_speed_baud_select;

  asp_baud_gen u_baud (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (run),
    .clear   (wr_brg | txen_rise | ab_done | ~m_q.serial_unit_on),
    .divisor (baud_divisor_q),
    .tick    (tick),
    .bclk    (bclk)
  );

  // ********************
  // Transmitter
  // ********************
  logic [8:0]       txf_data;
  logic [CW-1:0]    txf_cnt;
  logic             txf_full;
  logic             txf_empty;
  logic [14:0]      tsr_q;
  logic [3:0]       tleft_q;
  logic [3:0]       tph_q;
  logic             tbrk_q;
  logic             tx_go;
  logic             tx_bit_end;
  logic             tx_done;
  logic             tx_line;

  asp_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_txf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .flush   (~m_q.serial_unit_on),
    .push    (wr_tx),
    .wdata   ({hwdata[8] & ~req_q.byte_size, hwdata[7:0]}),
    .pop     (tx_go),
    .rdata   (txf_data),
    .count   (txf_cnt),
    .full    (txf_full),
    .empty   (txf_empty)
  );

  assign tx_go = run & txen_q & ~txf_empty & (tleft_q == 4'h0)
               & ((m_q.pin_usage_select != 2'h2) | ~clear_to_send_n);
  assign tx_bit_end  = tick & (tleft_q != 4'h0) & (tph_q == ovs_last);
  assign tx_done     = tx_bit_end & (tleft_q == 4'h1);
  assign tx_brk_done = tx_done & tbrk_q;
  assign tx_line     = tsr_q[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tsr_q   <= 15'h7fff;
      tleft_q <= 4'h0;
      tph_q   <= 4'h0;
      tbrk_q  <= 1'b0;
    end else if (!txen_q || !m_q.serial_unit_on) begin
      tsr_q   <= 15'h7fff;
      tleft_q <= 4'h0;
      tph_q   <= 4'h0;
      tbrk_q  <= 1'b0;
    end else if (tx_go) begin
      tph_q  <= 4'h0;
      tbrk_q <= brk_q;
      if (brk_q) begin
        tsr_q   <= BRK_FRAME;
        tleft_q <= BRK_LEN + {3'h0, m_q.stop_count_select};
      end else begin
        tsr_q   <= tx_frame(txf_data, m_q.parity_width_select);
        tleft_q <= ((m_q.parity_width_select == PW_8N) ? 4'ha : 4'hb)
                 + {3'h0, m_q.stop_count_select};
      end
    end else if (tx_bit_end) begin
      tph_q   <= 4'h0;
      tsr_q   <= {1'b1, tsr_q[14:1]};
      tleft_q <= tleft_q - 4'h1;
    end else if (tick && tleft_q != 4'h0) begin
      tph_q <= tph_q + 4'h1;
    end
  end

  // ********************
  // Receiver
  // ********************
  asp_rx_state_type rst_q;
  asp_rx_entry_type rxf_top;
  asp_rx_entry_type rx_new;
  logic [CW-1:0]    rxf_cnt;
  logic             rxf_full;
  logic             rxf_empty;
  logic [3:0]       rph_q;
  logic [3:0]       rcnt_q;
  logic [8:0]       rsh_q;
  logic             rx_prev_q;
  logic             ir_dec_q;
  logic [3:0]       ir_cnt_q;
  logic             rx_in;
  logic             rx_fall;
  logic             rx_stop;
  logic             push_try;
  logic             overrun_flag_clr;
  logic             rx_flush;

  assign rx_in = m_q.internal_echo_select ? tx_line
               : infrared_codec_enable_act ? ir_dec_q : (serial_in_pin ^ m_q.rx_polarity_invert);
  assign rx_fall  = rx_prev_q & ~rx_in;
  assign rx_stop  = (rst_q == RX_STOP) & tick & (rph_q == ovs_last);
  assign rx_new.data = (m_q.parity_width_select == PW_9N) ? rsh_q
                     : (m_q.parity_width_select == PW_8N) ? {1'b0, rsh_q[8:1]} : {1'b0, rsh_q[7:0]};
  assign rx_new.parity_error_flag = (m_q.parity_width_select == PW_8E) ? ^rsh_q
                     : (m_q.parity_width_select == PW_8O) ? ~^rsh_q : 1'b0;
  assign rx_new.framing_error_flag = ~rx_in;
  assign push_try = rx_stop & ~m_q.auto_rate_measure
                  & ~(adden_q & (m_q.parity_width_select == PW_9N) & ~rsh_q[8]);
  assign ovr      = push_try & rxf_full;
  assign overrun_flag_clr = overrun_flag_q & wr_sta & ~hwdata[STA_OVERRUN_FLAG] & ~ovr;
  assign rx_flush = overrun_flag_clr | ~m_q.serial_unit_on;
  assign wake_hit = m_q.wake_enable & sleep_mode & rx_fall;

  asp_fifo #(.WIDTH($bits(asp_rx_entry_type)), .DEPTH(DEPTH)) u_rxf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .flush   (rx_flush),
    .push    (push_try),
    .wdata   (rx_new),
    .pop     (rd_rx),
    .rdata   (rxf_top),
    .count   (rxf_cnt),
    .full    (rxf_full),
    .empty   (rxf_empty)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_flag_q <= 1'b0;
    end else if (ovr) begin
      overrun_flag_q <= 1'b1;
    end else if (overrun_flag_clr) begin
      overrun_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_dec_q <= 1'b1;
      ir_cnt_q <= 4'h0;
    end else if (serial_in_pin ^ m_q.rx_polarity_invert) begin
      ir_dec_q <= 1'b0;
      ir_cnt_q <= 4'h0;
    end else if (tick) begin
      if (ir_cnt_q == OVS_STD_LAST) begin
        ir_dec_q <= 1'b1;
      end else begin
        ir_cnt_q <= ir_cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_in;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_q  <= RX_IDLE;
      rph_q  <= 4'h0;
      rcnt_q <= 4'h0;
      rsh_q  <= 9'h000;
    end else if (rx_flush || !run) begin
      rst_q <= RX_IDLE;
      rsh_q <= 9'h000;
    end else begin
      unique case (rst_q)
        RX_IDLE: begin
          rph_q <= 4'h0;
          if (rx_fall) begin
            rst_q <= RX_START;
          end
        end
        RX_START: if (tick) begin
          rph_q <= rph_q + 4'h1;
          if (rph_q == ovs_half) begin
            rph_q  <= 4'h0;
            rcnt_q <= 4'h0;
            rst_q  <= rx_in ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: if (tick) begin
          rph_q <= rph_q + 4'h1;
          if (rph_q == ovs_last) begin
            rph_q  <= 4'h0;
            rsh_q  <= {rx_in, rsh_q[8:1]};
            rcnt_q <= rcnt_q + 4'h1;
            if (rcnt_q == ((m_q.parity_width_select == PW_8N) ? 4'h7 : 4'h8)) begin
              rst_q <= RX_STOP;
            end
          end
        end
        RX_STOP: if (tick) begin
          rph_q <= rph_q + 4'h1;
          if (rph_q == ovs_last) begin
            rst_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ********************
  // Auto-rate measurement over eight bit times of 0x55
  // ********************
  logic [23:0]      ab_cnt_q;
  logic [2:0]       ab_edges_q;

  assign ab_done = m_q.auto_rate_measure & rx_fall & (ab_edges_q == AB_LAST_EDGE);
  assign ab_div  = 16'((ab_cnt_q >> (m_q.high_speed_baud_select ? AB_SHIFT_HS : AB_SHIFT_STD)) - 24'h1);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_cnt_q   <= 24'h00_0000;
      ab_edges_q <= 3'h0;
    end else if (!m_q.auto_rate_measure || ab_done) begin
      ab_edges_q <= 3'h0;
    end else if (rx_fall) begin
      ab_edges_q <= ab_edges_q + 3'h1;
      if (ab_edges_q == 3'h0) begin
        ab_cnt_q <= 24'h00_0001;
      end else begin
        ab_cnt_q <= ab_cnt_q + 24'h1;
      end
    end else if (ab_edges_q != 3'h0) begin
      ab_cnt_q <= ab_cnt_q + 24'h1;
    end
  end

  // ********************
  // Read data, pins and events
  // ********************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_MODE: hrdata_q <= {16'h0000, m_q};
        ADDR_STA:  hrdata_q <= {16'h0000, txisel_q[1], txinv_q, txisel_q[0], 1'b0, brk_q, txen_q,
                               txf_full, (tleft_q == 4'h0) & txf_empty, rxisel_q, adden_q, rst_q == RX_IDLE,
                               rxf_top.parity_error_flag & ~rxf_empty, rxf_top.framing_error_flag & ~rxf_empty, overrun_flag_q, ~rxf_empty};
        ADDR_RX:   hrdata_q <= {23'h00_0000, rxf_top.data};
        ADDR_BRG:  hrdata_q <= {16'h0000, baud_divisor_q};
        default:   hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_pin     <= 1'b1;
      serial_out_oe      <= 1'b0;
      request_to_send_n  <= 1'b1;
      request_to_send_oe <= 1'b0;
    end else begin
      serial_out_oe      <= m_q.serial_unit_on & txen_q;
      serial_out_pin     <= infrared_codec_enable_act
                          ? (~tx_line & (tleft_q != 4'h0) & (tph_q >= IR_PULSE_LO) & (tph_q <= IR_PULSE_HI)) ^ txinv_q
                          : tx_line;
      request_to_send_oe <= m_q.serial_unit_on & (m_q.pin_usage_select != 2'h0);
      if (m_q.pin_usage_select == 2'h3) begin
        request_to_send_n <= bclk;
      end else if (m_q.rts_behaviour_select) begin
        request_to_send_n <= tleft_q == 4'h0;
      end else begin
        request_to_send_n <= rxf_full;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_irq   <= 1'b0;
      rx_irq   <= 1'b0;
      err_irq  <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      tx_irq   <= txen_rise
                | (tx_go & (txisel_q == 2'h0))
                | (tx_go & (txisel_q == 2'h2) & (txf_cnt == CW'(1)))
                | (tx_done & txf_empty & (txisel_q == 2'h1));
      rx_irq   <= push_try & ~rxf_full & (~rxisel_q[1]
                | ((rxisel_q == 2'h2) & (rxf_cnt == CW'(2)))
                | ((rxisel_q == 2'h3) & (rxf_cnt == CW'(DEPTH - 1))));
      err_irq  <= ovr | (push_try & (rx_new.parity_error_flag | rx_new.framing_error_flag));
      wake_irq <= wake_hit;
    end
  end

endmodule
`default_nettype wire

/* verification/asp_chk_sva.sv */
// Checker for bus answers and event pulses of the serial port
`timescale 1ns/1ps
`default_nettype none
module asp_chk (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Inputs seen
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        sleep_mode,
  // Outputs watched
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        tx_irq,
  input wire logic        rx_irq,
  input wire logic        err_irq,
  input wire logic        wake_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  zero_wait_a: assert property (hreadyout) else $error("wait state");
  resp_okay_a: assert property (!hresp) else $error("error response");
  rdata_hold_a: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data moved");
  tx_pulse_a: assert property (tx_irq ##1 tx_irq |=> !tx_irq) else $error("long tx pulse");
  rx_pulse_a: assert property (rx_irq |=> !rx_irq) else $error("long rx pulse");
  err_pulse_a: assert property (err_irq |=> !err_irq) else $error("long err pulse");
  wake_pulse_a: assert property (wake_irq |=> !wake_irq) else $error("long wake pulse");
  wake_sleep_a: assert property (wake_irq |-> $past(sleep_mode)) else $error("wake while awake");
endmodule
bind asp_top asp_chk chk_u (.sys_clk, .rst_n, .hsel, .hready, .htrans, .hwrite, .sleep_mode, .hreadyout,
  .hresp, .hrdata, .tx_irq, .rx_irq, .err_irq, .wake_irq);
`default_nettype wire

/* verification/asp_remote.sv */
// Remote serial device driving the receive line
`timescale 1ns/1ps
`default_nettype none
module asp_remote (
  // Clock
  input  wire logic sys_clk,
  // Line side
  output logic      line,
  output logic      clear_to_send_n
);
  initial begin
    line = 1'b1;
    clear_to_send_n = 1'b0;
  end
  // Start, data LSB first, one stop, eight clocks a bit
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= fr[i];
      repeat (8) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

/* verification/asp_top_test.sv */
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module asp_top_test;
  import asp_pkg::*;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic        hreadyout, hresp, serial_in_pin, serial_out_pin, clear_to_send_n, tx_irq;
  logic        sleep_mode = 1'b0, rx_irq, err_irq, wake_irq;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, txi = 0, rxi = 0, eri = 0, wki = 0;
  always #4 sys_clk = ~sys_clk;
  asp_remote rem_u (.sys_clk, .line(serial_in_pin), .clear_to_send_n);
  asp_top dut_u (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .idle_mode(1'b0), .sleep_mode, .serial_in_pin,
    .serial_out_pin, .serial_out_oe(), .clear_to_send_n, .request_to_send_n(), .request_to_send_oe(),
    .tx_irq, .rx_irq, .err_irq, .wake_irq);
  // ****
  // Tasks
  // ****
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Line is looked at on falling edges, mid-bit, once it has settled
  task automatic frame(input logic [15:0] fr, input int n);
    while (serial_out_pin !== 1'b1) @(negedge sys_clk);
    while (serial_out_pin !== 1'b0) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < n; i++) begin
      chk(32'(serial_out_pin), 32'(fr[i]));
      repeat (8) @(negedge sys_clk);
    end
    @(posedge sys_clk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  // Event pulses are counted where they have settled
  always @(negedge sys_clk) begin
    if (tx_irq === 1'b1) txi++;
    if (rx_irq === 1'b1) rxi++;
    if (err_irq === 1'b1) eri++;
    if (wake_irq === 1'b1) wki++;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    bus(ADDR_MODE, 1'b1, 32'h0000_c408);
    bus(ADDR_MODE, 1'b0, '0);
    chk(r, 32'h0000_8008);
    bus(8'h20, 1'b0, '0);
    chk(r, '0);
    bus(ADDR_BRG, 1'b1, 32'h0000_0001);
    bus(ADDR_TX, 1'b1, 32'h0000_00a5);
    bus(ADDR_STA, 1'b1, 32'h0000_0400);
    frame(16'h034a, 10);
    chk(32'(txi), 32'h0000_0002);
    for (int i = 0; i < 5; i++) rem_u.send(8'h31 + 8'(i));
    repeat (40) @(posedge sys_clk);
    chk(32'(rxi), 32'h0000_0004);
    chk(32'(eri), 32'h0000_0001);
    bus(ADDR_STA, 1'b0, '0);
    chk(r & 32'h0000_0003, 32'h0000_0003);
    bus(ADDR_RX, 1'b0, '0);
    chk(r, 32'h0000_0031);
    bus(ADDR_STA, 1'b1, 32'h0000_0400);
    bus(ADDR_STA, 1'b0, '0);
    chk(r & 32'h0000_0003, '0);
    bus(ADDR_STA, 1'b1, 32'h0000_0c00);
    bus(ADDR_TX, 1'b1, 32'h0000_00ff);
    bus(ADDR_TX, 1'b1, 32'h0000_0055);
    frame(16'h0000, 13);
    frame(16'h02aa, 10);
    bus(ADDR_STA, 1'b0, '0);
    chk(r & 32'h0000_0800, '0);
    bus(ADDR_MODE, 1'b1, 32'h0000_8088);
    sleep_mode <= 1'b1;
    rem_u.send(8'h5a);
    sleep_mode <= 1'b0;
    bus(ADDR_MODE, 1'b0, '0);
    chk(r, 32'h0000_8008);
    chk(32'(wki), 32'h0000_0001);
    final_report;
  end
endmodule
`default_nettype wire
